// ---- src/tpdr_pkg.sv ----
// Constants for the transceiver PLL divider register block.
// Assumes a 16-bit reconfiguration port with word addresses.
package tpdr_pkg;

  // ------------------------------------------------------------
  // Port geometry
  // ------------------------------------------------------------
  localparam int ADDR_W = 9; // Word address width
  localparam int DATA_W = 16; // Word width

  // ------------------------------------------------------------
  // Word addresses
  // ------------------------------------------------------------
  localparam logic [8:0] ADDR_QUAD_CFG_LO = 9'h032; // Quad config low word
  localparam logic [8:0] ADDR_QUAD_CFG_HI = 9'h033; // Quad refdiv and config high
  localparam logic [8:0] ADDR_QUAD_FBDIV = 9'h036; // Quad feedback divider
  localparam logic [8:0] ADDR_QUAD_RATIO = 9'h037; // Quad feedback ratio
  localparam logic [8:0] ADDR_CHAN_CFG_LO = 9'h05C; // Channel config low
  localparam logic [8:0] ADDR_CHAN_CFG_HI = 9'h05D; // Channel config high
  localparam logic [8:0] ADDR_CHAN_DIV = 9'h05E; // Channel dividers
  localparam logic [8:0] ADDR_OUT_DIV = 9'h088; // Output dividers

  // ------------------------------------------------------------
  // Implemented bits per word; the rest read as zero
  // ------------------------------------------------------------
  localparam logic [15:0] MASK_QUAD_CFG_LO = 16'hFFFF;
  localparam logic [15:0] MASK_QUAD_CFG_HI = 16'hFFFF;
  localparam logic [15:0] MASK_QUAD_FBDIV = 16'h03FF;
  localparam logic [15:0] MASK_QUAD_RATIO = 16'h0040;
  localparam logic [15:0] MASK_CHAN_CFG_LO = 16'hFF00;
  localparam logic [15:0] MASK_CHAN_CFG_HI = 16'hFFFF;
  localparam logic [15:0] MASK_CHAN_DIV = 16'h1FFF;
  localparam logic [15:0] MASK_OUT_DIV = 16'h0077;

  // ------------------------------------------------------------
  // Reset values (none documented; plain zero)
  // ------------------------------------------------------------
  localparam logic [15:0] RST_QUAD_CFG_LO = 16'h0000;
  localparam logic [15:0] RST_QUAD_CFG_HI = 16'h0000;
  localparam logic [15:0] RST_QUAD_FBDIV = 16'h0000;
  localparam logic [15:0] RST_QUAD_RATIO = 16'h0000;
  localparam logic [15:0] RST_CHAN_CFG_LO = 16'h0000;
  localparam logic [15:0] RST_CHAN_CFG_HI = 16'h0000;
  localparam logic [15:0] RST_CHAN_DIV = 16'h0000;
  localparam logic [15:0] RST_OUT_DIV = 16'h0000;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int TX_DIV_LSB = 4; // Transmit output divider 6:4
  localparam int RX_DIV_LSB = 0; // Receive output divider 2:0
  localparam int QREF_LSB = 11; // Quad reference divider 15:11
  localparam int QCFG_HI_W = 11; // Quad config bits 26:16 in 10:0
  localparam int QBAND_BIT = 6; // Band select inside config word
  localparam int QRATIO_BIT = 6; // Feedback ratio bit
  localparam int CREF_LSB = 8; // Channel reference divider 12:8
  localparam int CRATIO_BIT = 7; // Channel ratio select
  localparam int CFB_LSB = 0; // Channel feedback divider 6:0
  localparam int CCFG_LO_LSB = 8; // Channel config 7:0 in 15:8

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  localparam logic [2:0] OUTDIV_MAX_CODE = 3'h4; // Divide by 16
  localparam logic [9:0] QFB_RATIO0_VALUE = 10'h042; // Divide 66 needs ratio 0

endpackage

// ---- src/tpdr_reg16.sv ----
// One 16-bit reconfiguration word with masked storage.
// Assumes write strobe and data come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module tpdr_reg16 #(
  parameter logic [15:0] MASK = 16'hFFFF, // Implemented bits
  parameter logic [15:0] RST_VAL = 16'h0000 // Value after reset
) (
  input wire logic mclk, // Block clock
  input wire logic rst, // Synchronous reset, high
  input wire logic wr_en, // Write this word
  input wire logic [15:0] wr_data, // Data to write
  output logic [15:0] q // Stored word
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // Unimplemented bits hold zero so reads show zero there
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      q <= RST_VAL & MASK;
    end
    else if (wr_en)
    begin
      q <= wr_data & MASK;
    end
  end

endmodule

`default_nettype wire

// ---- src/tpdr_regs.sv ----
// Transceiver PLL divider registers behind the reconfiguration port.
// Assumes the port master runs on mclk and waits for ready per access.
//
// Summary of operation
// R1: Output dividers at 0088, bits 6:4, 2:0
// R2: Band change needs config bit 6 rewrite
// R3: Quad config split over 0032 and 0033
// R4: Quad feedback divider limited to eight values; the block stores any 10-bit value
// R5: Feedback ratio bit zero only for 66
// R6: Quad reference divider in 0033 bits 15:11
// R7: Channel dividers packed into word 005E
// R8: Output divider sets line rate from PLL
// R9: Quad words reachable only when enabled, selected
// R10: Shared words changed by read-modify-write
`timescale 1ns/1ps
`default_nettype none

module tpdr_regs #(
  parameter bit QUAD_BUS_EN = 1'b1 // Quad word access on the register bus built in
) (
  input wire logic mclk, // Block clock, 10 MHz
  input wire logic rst, // Synchronous reset, high
  input wire logic quad_pll_selected, // Quad PLL chosen as clock source
  input wire logic rp_en, // Port access strobe, one cycle
  input wire logic rp_we, // Write when high with strobe
  input wire logic [tpdr_pkg::ADDR_W-1:0] rp_addr, // Word address
  input wire logic [tpdr_pkg::DATA_W-1:0] rp_di, // Write data
  output logic [tpdr_pkg::DATA_W-1:0] rp_do, // Read data
  output logic rp_rdy, // Access done, one cycle
  output logic [2:0] transmit_output_divider, // Transmit divide code
  output logic [2:0] receive_output_divider, // Receive divide code
  output logic outdiv_code_error, // An output divider code above 4
  output logic [26:0] quad_pll_config_word, // Quad config attribute
  output logic quad_pll_band_lower, // Band select, high for lower band
  output logic [4:0] quad_pll_reference_divider, // Quad reference code
  output logic [9:0] quad_pll_feedback_divider, // Quad feedback value
  output logic quad_pll_feedback_ratio, // Quad ratio bit
  output logic quad_ratio_mismatch, // Ratio bit disagrees with divider
  output logic [23:0] channel_pll_config_word, // Channel config attribute
  output logic [4:0] channel_pll_reference_divider, // Channel reference code
  output logic channel_pll_ratio_select, // Channel ratio, 1 for five
  output logic [6:0] channel_pll_feedback_divider // Channel feedback code
);

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  logic quad_open; // Quad words visible
  logic wr; // Write strobe
  logic sel_qlo; // Address hits quad config low
  logic sel_qhi; // Address hits quad refdiv and config high
  logic sel_qfb; // Address hits quad feedback divider
  logic sel_qra; // Address hits quad ratio
  logic sel_clo; // Address hits channel config low
  logic sel_chi; // Address hits channel config high
  logic sel_cdv; // Address hits channel dividers
  logic sel_odv; // Address hits output dividers

  // Quad words exist only with the bus built and the quad PLL in use
  assign quad_open = QUAD_BUS_EN && quad_pll_selected; // R9
  assign wr = rp_en && rp_we;
  assign sel_qlo = quad_open && (rp_addr == tpdr_pkg::ADDR_QUAD_CFG_LO); // R9
  assign sel_qhi = quad_open && (rp_addr == tpdr_pkg::ADDR_QUAD_CFG_HI); // R9
  assign sel_qfb = quad_open && (rp_addr == tpdr_pkg::ADDR_QUAD_FBDIV); // R9
  assign sel_qra = quad_open && (rp_addr == tpdr_pkg::ADDR_QUAD_RATIO); // R9
  assign sel_clo = (rp_addr == tpdr_pkg::ADDR_CHAN_CFG_LO);
  assign sel_chi = (rp_addr == tpdr_pkg::ADDR_CHAN_CFG_HI);
  assign sel_cdv = (rp_addr == tpdr_pkg::ADDR_CHAN_DIV);
  assign sel_odv = (rp_addr == tpdr_pkg::ADDR_OUT_DIV);

  // ------------------------------------------------------------
  // Register words
  // ------------------------------------------------------------
  logic [15:0] qlo_q; // Quad config 15:0
  logic [15:0] qhi_q; // Quad refdiv and config 26:16
  logic [15:0] qfb_q; // Quad feedback divider
  logic [15:0] qra_q; // Quad feedback ratio
  logic [15:0] clo_q; // Channel config 7:0 in upper byte
  logic [15:0] chi_q; // Channel config 23:8
  logic [15:0] cdv_q; // Channel dividers
  logic [15:0] odv_q; // Output dividers

  // Whole-word writes; software keeps neighbour fields itself
  tpdr_reg16 #(.MASK(tpdr_pkg::MASK_QUAD_CFG_LO), .RST_VAL(tpdr_pkg::RST_QUAD_CFG_LO)) u_qlo (
    .mclk(mclk), .rst(rst), .wr_en(wr && sel_qlo), .wr_data(rp_di), .q(qlo_q)); // R3
  tpdr_reg16 #(.MASK(tpdr_pkg::MASK_QUAD_CFG_HI), .RST_VAL(tpdr_pkg::RST_QUAD_CFG_HI)) u_qhi (
    .mclk(mclk), .rst(rst), .wr_en(wr && sel_qhi), .wr_data(rp_di), .q(qhi_q)); // R6
  tpdr_reg16 #(.MASK(tpdr_pkg::MASK_QUAD_FBDIV), .RST_VAL(tpdr_pkg::RST_QUAD_FBDIV)) u_qfb (
    .mclk(mclk), .rst(rst), .wr_en(wr && sel_qfb), .wr_data(rp_di), .q(qfb_q));
  tpdr_reg16 #(.MASK(tpdr_pkg::MASK_QUAD_RATIO), .RST_VAL(tpdr_pkg::RST_QUAD_RATIO)) u_qra (
    .mclk(mclk), .rst(rst), .wr_en(wr && sel_qra), .wr_data(rp_di), .q(qra_q));
  tpdr_reg16 #(.MASK(tpdr_pkg::MASK_CHAN_CFG_LO), .RST_VAL(tpdr_pkg::RST_CHAN_CFG_LO)) u_clo (
    .mclk(mclk), .rst(rst), .wr_en(wr && sel_clo), .wr_data(rp_di), .q(clo_q));
  tpdr_reg16 #(.MASK(tpdr_pkg::MASK_CHAN_CFG_HI), .RST_VAL(tpdr_pkg::RST_CHAN_CFG_HI)) u_chi (
    .mclk(mclk), .rst(rst), .wr_en(wr && sel_chi), .wr_data(rp_di), .q(chi_q));
  tpdr_reg16 #(.MASK(tpdr_pkg::MASK_CHAN_DIV), .RST_VAL(tpdr_pkg::RST_CHAN_DIV)) u_cdv (
    .mclk(mclk), .rst(rst), .wr_en(wr && sel_cdv), .wr_data(rp_di), .q(cdv_q)); // R7
  tpdr_reg16 #(.MASK(tpdr_pkg::MASK_OUT_DIV), .RST_VAL(tpdr_pkg::RST_OUT_DIV)) u_odv (
    .mclk(mclk), .rst(rst), .wr_en(wr && sel_odv), .wr_data(rp_di), .q(odv_q)); // R1

  // ------------------------------------------------------------
  // Port answer
  // ------------------------------------------------------------
  logic [15:0] rd_d; // Read mux result

  // Unmapped or closed addresses read zero
  always_comb
  begin
    rd_d = 16'h0000;
    if (sel_qlo)
    begin
      rd_d = qlo_q;
    end
    else if (sel_qhi)
    begin
      rd_d = qhi_q;
    end
    else if (sel_qfb)
    begin
      rd_d = qfb_q;
    end
    else if (sel_qra)
    begin
      rd_d = qra_q;
    end
    else if (sel_clo)
    begin
      rd_d = clo_q;
    end
    else if (sel_chi)
    begin
      rd_d = chi_q;
    end
    else if (sel_cdv)
    begin
      rd_d = cdv_q;
    end
    else if (sel_odv)
    begin
      rd_d = odv_q;
    end
  end

  // Ready one cycle after every strobe; data held until next read
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rp_rdy <= 1'b0;
      rp_do <= 16'h0000;
    end
    else
    begin
      rp_rdy <= rp_en;
      if (rp_en && !rp_we)
      begin
        rp_do <= rd_d;
      end
    end
  end

  // ------------------------------------------------------------
  // Field outputs
  // ------------------------------------------------------------
  // Output dividers shared by both PLL types
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      transmit_output_divider <= 3'h0;
      receive_output_divider <= 3'h0;
      outdiv_code_error <= 1'b0;
    end
    else
    begin
      transmit_output_divider <= odv_q[tpdr_pkg::TX_DIV_LSB +: 3]; // R1
      receive_output_divider <= odv_q[tpdr_pkg::RX_DIV_LSB +: 3]; // R1
      // Codes 0 to 4 give ratios 1 to 16; others are unusable
      outdiv_code_error <= (odv_q[tpdr_pkg::TX_DIV_LSB +: 3] > tpdr_pkg::OUTDIV_MAX_CODE)
        || (odv_q[tpdr_pkg::RX_DIV_LSB +: 3] > tpdr_pkg::OUTDIV_MAX_CODE); // R8
    end
  end

  // Quad PLL fields
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      quad_pll_config_word <= 27'h0000000;
      quad_pll_band_lower <= 1'b0;
      quad_pll_reference_divider <= 5'h00;
      quad_pll_feedback_divider <= 10'h000;
      quad_pll_feedback_ratio <= 1'b0;
      quad_ratio_mismatch <= 1'b0;
    end
    else
    begin
      quad_pll_config_word <= {qhi_q[tpdr_pkg::QCFG_HI_W-1:0], qlo_q}; // R3
      quad_pll_band_lower <= qlo_q[tpdr_pkg::QBAND_BIT]; // R2
      quad_pll_reference_divider <= qhi_q[tpdr_pkg::QREF_LSB +: 5]; // R6
      quad_pll_feedback_divider <= qfb_q[9:0]; // R4
      quad_pll_feedback_ratio <= qra_q[tpdr_pkg::QRATIO_BIT];
      // Ratio must be zero exactly when the divider is 66
      quad_ratio_mismatch <= qra_q[tpdr_pkg::QRATIO_BIT]
        == (qfb_q[9:0] == tpdr_pkg::QFB_RATIO0_VALUE); // R5
    end
  end

  // Channel PLL fields
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      channel_pll_config_word <= 24'h000000;
      channel_pll_reference_divider <= 5'h00;
      channel_pll_ratio_select <= 1'b0;
      channel_pll_feedback_divider <= 7'h00;
    end
    else
    begin
      channel_pll_config_word <= {chi_q, clo_q[tpdr_pkg::CCFG_LO_LSB +: 8]};
      channel_pll_reference_divider <= cdv_q[tpdr_pkg::CREF_LSB +: 5]; // R7
      channel_pll_ratio_select <= cdv_q[tpdr_pkg::CRATIO_BIT]; // R7
      channel_pll_feedback_divider <= cdv_q[tpdr_pkg::CFB_LSB +: 7]; // R7
    end
  end

endmodule

`default_nettype wire

// ---- test/tpdr_regs_properties.sv ----
// Checker for the PLL divider register block, bound to its top.
// Assumes the default quad bus build and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module tpdr_regs_properties (
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic quad_pll_selected, // Quad gate
  input wire logic rp_en, // Strobe
  input wire logic rp_we, // Write
  input wire logic [8:0] rp_addr, // Address
  input wire logic [15:0] rp_di, // Write data
  input wire logic [15:0] rp_do, // Read data
  input wire logic rp_rdy, // Done
  input wire logic [2:0] transmit_output_divider, // Tx code
  input wire logic [2:0] receive_output_divider, // Rx code
  input wire logic [26:0] quad_pll_config_word, // Quad config
  input wire logic quad_pll_band_lower, // Band
  input wire logic [4:0] quad_pll_reference_divider, // Quad ref
  input wire logic [4:0] channel_pll_reference_divider, // Chan ref
  input wire logic channel_pll_ratio_select, // Chan ratio
  input wire logic [6:0] channel_pll_feedback_divider // Chan fb
);
  // ----------------------------------------
  // Clocking and helpers
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic wr; // Write strobe
  assign wr = rp_en && rp_we;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rdy;
    !$past(rst) |-> rp_rdy == $past(rp_en);
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready not one cycle after strobe");
  property p_outdiv;
    wr && rp_addr == 9'h088 |-> ##2 {transmit_output_divider, receive_output_divider}
      == {$past(rp_di[6:4], 2), $past(rp_di[2:0], 2)};
  endproperty
  a_outdiv: assert property (p_outdiv) else $error("output dividers wrong");
  property p_qlo;
    wr && rp_addr == 9'h032 && quad_pll_selected |-> ##2
      quad_pll_config_word[15:0] == $past(rp_di, 2) && quad_pll_band_lower == $past(rp_di[6], 2);
  endproperty
  a_qlo: assert property (p_qlo) else $error("quad config low wrong");
  property p_qhi;
    wr && rp_addr == 9'h033 && quad_pll_selected |-> ##2
      {quad_pll_reference_divider, quad_pll_config_word[26:16]} == $past(rp_di, 2);
  endproperty
  a_qhi: assert property (p_qhi) else $error("quad config high wrong");
  property p_cdiv;
    wr && rp_addr == 9'h05E |-> ##2 {channel_pll_reference_divider, channel_pll_ratio_select,
      channel_pll_feedback_divider} == $past(rp_di[12:0], 2);
  endproperty
  a_cdiv: assert property (p_cdiv) else $error("channel dividers wrong");
  property p_gate;
    rp_en && !rp_we && !quad_pll_selected && rp_addr inside {9'h032, 9'h033, 9'h036, 9'h037}
      |=> rp_do == 16'h0000;
  endproperty
  a_gate: assert property (p_gate) else $error("gated quad word readable");
  sequence s_b2b;
    wr && rp_addr == 9'h088 ##1 rp_en && !rp_we && rp_addr == 9'h088;
  endsequence
  property p_b2b;
    s_b2b |=> rp_do == ($past(rp_di, 2) & 16'h0077);
  endproperty
  a_b2b: assert property (p_b2b) else $error("read after write wrong");
  c_outdiv: cover property (wr && rp_addr == 9'h088);
  c_gate: cover property (rp_en && !quad_pll_selected);
  c_b2b: cover property (s_b2b);
endmodule
bind tpdr_regs tpdr_regs_properties tpdr_regs_properties_inst (.*);
`default_nettype wire

// ---- test/tpdr_regs_tb_top.sv ----
// Self-checking bench for the PLL divider register block.
// Assumes the checker file is compiled alongside and binds itself.
`timescale 1ns/1ps
`default_nettype none
module tpdr_regs_tb_top;
  logic mclk, rst, sel, en, we, rdy, ode, band, qratio, qmis, cratio; // Controls, flags
  logic [8:0] addr; // Word address
  logic [15:0] di, rdata; // Data
  logic [2:0] txd, rxd; // Output divider codes
  logic [26:0] qcfg; // Quad config
  logic [4:0] qref, cref; // Reference codes
  logic [9:0] qfb; // Quad feedback
  logic [23:0] ccfg; // Channel config
  logic [6:0] cfb; // Channel feedback
  logic [15:0] cv; // Scratch word
  int n_mismatch = 0; // Mismatches
  int checks_done = 0; // Compares
  logic [8:0] amap [8] = '{9'h032, 9'h033, 9'h036, 9'h037, 9'h05C, 9'h05D, 9'h05E, 9'h088};
  logic [15:0] mmap [8] = '{16'hFFFF, 16'hFFFF, 16'h03FF, 16'h0040, 16'hFF00, 16'hFFFF,
    16'h1FFF, 16'h0077};
  int fbv [8] = '{16, 20, 32, 40, 64, 66, 80, 100};
  tpdr_regs tpdr_regs_inst (.mclk(mclk), .rst(rst), .quad_pll_selected(sel), .rp_en(en),
    .rp_we(we), .rp_addr(addr), .rp_di(di), .rp_do(rdata), .rp_rdy(rdy),
    .transmit_output_divider(txd), .receive_output_divider(rxd), .outdiv_code_error(ode),
    .quad_pll_config_word(qcfg), .quad_pll_band_lower(band), .quad_pll_reference_divider(qref),
    .quad_pll_feedback_divider(qfb), .quad_pll_feedback_ratio(qratio),
    .quad_ratio_mismatch(qmis), .channel_pll_config_word(ccfg),
    .channel_pll_reference_divider(cref), .channel_pll_ratio_select(cratio),
    .channel_pll_feedback_divider(cfb));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [26:0] seen, input logic [26:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [8:0] a, input logic [15:0] d);
    en = 1'b1;
    we = w;
    addr = a;
    di = d;
    @(negedge mclk);
    chk("ready", rdy, 27'h1);
  endtask
  task automatic idle();
    en = 1'b0;
    @(negedge mclk);
    chk("ready idle", rdy, 27'h0);
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
    idle();
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk("read data", rdata, {11'h000, e});
    idle();
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial
  begin
    #1000000;
    n_mismatch++;
    close_out();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    sel = 1'b1;
    en = 1'b0;
    we = 1'b0;
    addr = 9'h000;
    di = 16'h0000;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    for (int i = 0; i < 8; i++)
    begin
      rd(amap[i], 16'h0000);
      wr(amap[i], 16'hFFFF);
      rd(amap[i], mmap[i]);
    end
    for (int i = 0; i < 5; i++)
    begin
      wr(9'h088, {9'h000, 3'(i), 1'b0, 3'(4 - i)});
      chk("tx div", txd, 27'(i));
      chk("rx div", rxd, 27'(4 - i));
      chk("code error", ode, 27'h0);
    end
    acc(1'b1, 9'h088, 16'h0023);
    acc(1'b0, 9'h088, 16'h0000);
    chk("read after write", rdata, 27'h23);
    idle();
    wr(9'h088, (rdata & 16'hFF8F) | 16'h0050);
    chk("code error", ode, 27'h1);
    wr(9'h032, 16'h0040);
    chk("band", band, 27'h1);
    wr(9'h032, 16'hA5BF);
    chk("band", band, 27'h0);
    for (int i = 0; i < 4; i++)
    begin
      cv = {(i == 0) ? 5'h10 : 5'(i - 1), 11'h5A5};
      wr(9'h033, cv);
      chk("quad ref", qref, 27'(cv[15:11]));
      chk("quad cfg", qcfg, {11'h5A5, 16'hA5BF});
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(9'h036, 16'(fbv[i]));
      wr(9'h037, (fbv[i] == 66) ? 16'h0000 : 16'h0040);
      idle();
      chk("quad fb", qfb, 27'(fbv[i]));
      chk("ratio", qratio, 27'(fbv[i] != 66));
      chk("ratio flag", qmis, 27'h0);
    end
    // Ratio cleared with divider 100 must raise the flag
    wr(9'h037, 16'h0000);
    chk("ratio flag bad", qmis, 27'h1);
    for (int i = 0; i < 5; i++)
    begin
      cv = {3'h0, i[0] ? 5'h10 : 5'h00, i[1], (i == 0) ? 7'h10 : 7'(i - 1)};
      wr(9'h05E, cv);
      chk("chan ref", cref, 27'(cv[12:8]));
      chk("chan ratio", cratio, 27'(cv[7]));
      chk("chan fb", cfb, 27'(cv[6:0]));
    end
    wr(9'h05C, 16'hAB00);
    wr(9'h05D, 16'h1234);
    chk("chan cfg", ccfg, 27'h1234AB);
    sel = 1'b0;
    wr(9'h032, 16'h1111);
    rd(9'h032, 16'h0000);
    sel = 1'b1;
    rd(9'h032, 16'hA5BF);
    wr(9'h100, 16'hFFFF);
    rd(9'h100, 16'h0000);
    // Mid-run reset: fields back to zero, ratio flag set
    rst = 1'b1;
    @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk("reset tx div", txd, 27'h0);
    chk("reset code error", ode, 27'h0);
    chk("reset ratio flag", qmis, 27'h1);
    rd(9'h088, 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
